// >>> logic/can_filter_defs.svh
`ifndef CAN_FILTER_DEFS_SVH
`define CAN_FILTER_DEFS_SVH

// Direct register offsets (outside the paged window)
`define ADDR_PAGE_SELECT 8'h6F
`define ADDR_INIT_CONTROL 8'h68
// Paged window bounds
`define WINDOW_BASE 8'h70
`define WINDOW_ODD_BASE 8'h78
// Page numbers
`define PAGE_FILTERS_01 3'h2
`define PAGE_FILTERS_23 3'h3
`define PAGE_FILTERS_45 3'h4
`define PAGE_CONFIG 3'h6
// Configuration page offsets
`define ADDR_MODE_LOW_GROUP 8'h78
`define ADDR_MODE_HIGH_GROUP 8'h79
`define ADDR_CONFIG_PAIR_01 8'h7A
`define ADDR_CONFIG_PAIR_23 8'h7B
`define ADDR_CONFIG_PAIR_45 8'h7C
// Field positions inside a pair configuration register
`define ACTIVE_EVEN_BIT 0
`define SCALE_EVEN_LSB 1
`define FIFO_EVEN_BIT 3
`define ACTIVE_ODD_BIT 4
`define SCALE_ODD_LSB 5
`define FIFO_ODD_BIT 7
// Writable masks and reset values
`define CONFIG_WRITE_MASK 8'h77
`define CONFIG_RESET 8'h00
`define MODE_HIGH_GROUP_MASK 8'h0F
`define MODE_RESET 8'h00
`define PAGE_RESET 3'h0
`define INIT_CONTROL_RESET 1'b1

`endif

// >>> logic/can_filter_pkg.sv
package can_filter_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [2:0] page_type;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_READ = 2'b01
  } bus_phase_type;
endpackage

// >>> logic/filter_store_if.sv
`timescale 1ns/1ps
interface filter_store_if;
  logic write_enable;
  logic [5:0] write_index;
  logic [7:0] write_data;
  logic [5:0] read_index;
  logic [7:0] read_data;
  modport owner (output write_enable, output write_index, output write_data, output read_index, input read_data);
  modport store (input write_enable, input write_index, input write_data, input read_index, output read_data);
endinterface

// >>> logic/filter_bit_store.sv
`timescale 1ns/1ps
// Forty-eight filter-bit bytes, eight per filter; no reset, contents start undefined
module filter_bit_store (
  input wire logic CLOCK,
  filter_store_if.store port
);
  logic [7:0] storage [0:47];

  // Plain write port; read is combinational, registered by the owner
  always_ff @(posedge CLOCK) begin
    if (port.write_enable) begin
      storage[port.write_index] <= port.write_data;
    end
  end

  assign port.read_data = storage[port.read_index];
endmodule

// >>> logic/can_acceptance_filter_config.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "can_filter_defs.svh"
module can_acceptance_filter_config (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [7:0] ADDRESS,
  input wire can_filter_pkg::byte_type WRITE_DATA,
  input wire logic WRITE_STROBE,
  input wire logic READ_STROBE,
  output can_filter_pkg::byte_type READ_DATA,
  output logic [5:0] FILTER_ACTIVE,
  output logic [11:0] FILTER_SCALE,
  output logic [5:0] HIGH_HALF_LIST_MODE,
  output logic [5:0] LOW_HALF_LIST_MODE,
  output logic [5:0] FILTER_FIFO_ASSIGN
);
  import can_filter_pkg::*;

  byte_type filter_mode_low_group;
  byte_type filter_mode_high_group;
  byte_type filter_config_pair_01;
  byte_type filter_config_pair_23;
  byte_type filter_config_pair_45;
  page_type page_number;
  logic init_mode;
  byte_type direct_read;
  byte_type next_read_data;
  logic [5:0] active_all;
  logic window_hit;
  logic [2:0] window_pair;
  logic [5:0] byte_index;
  logic byte_page;
  logic byte_write_ok;

  filter_store_if store_port ();

  filter_bit_store bytes_inst (
    .CLOCK(CLOCK),
    .port(store_port)
  );

  // Pair config write: reserved bits stay zero, scale held outside init mode
  function automatic byte_type merge_config(input byte_type old_value, input byte_type new_value,
                                            input logic init);
    byte_type result;
    result = new_value & `CONFIG_WRITE_MASK;
    if (!init) begin
      result[`SCALE_EVEN_LSB +: 2] = old_value[`SCALE_EVEN_LSB +: 2];
      result[`SCALE_ODD_LSB +: 2] = old_value[`SCALE_ODD_LSB +: 2];
    end
    return result;
  endfunction

  // Map a window offset on a filter page to a byte slot 0..47
  function automatic logic [5:0] slot_of(input page_type page, input byte_type addr);
    logic [2:0] pair;
    pair = page - `PAGE_FILTERS_01;
    return {pair, 3'b000} + {pair, 3'b000} + {2'b00, addr[3:0]};
  endfunction

  assign active_all = {filter_config_pair_45[`ACTIVE_ODD_BIT], filter_config_pair_45[`ACTIVE_EVEN_BIT],
                       filter_config_pair_23[`ACTIVE_ODD_BIT], filter_config_pair_23[`ACTIVE_EVEN_BIT],
                       filter_config_pair_01[`ACTIVE_ODD_BIT], filter_config_pair_01[`ACTIVE_EVEN_BIT]};

  // Window decode; page 2 is filters 0/1, even filter in the low eight bytes
  assign window_hit = ((ADDRESS & 8'hF0) == `WINDOW_BASE);
  assign byte_page = (page_number == `PAGE_FILTERS_01) || (page_number == `PAGE_FILTERS_23) ||
                     (page_number == `PAGE_FILTERS_45);
  assign window_pair = page_number - `PAGE_FILTERS_01;
  assign byte_index = slot_of(page_number, ADDRESS);
  // An active filter locks its bytes so the matcher never sees a half-written pattern
  assign byte_write_ok = !active_all[{window_pair[1:0], ADDRESS[3]}];

  // Store port: bytes are opaque here, identifier/mask meaning lives in the matcher
  assign store_port.write_enable = WRITE_STROBE && window_hit && byte_page && byte_write_ok;
  assign store_port.write_index = byte_index;
  assign store_port.write_data = WRITE_DATA;
  assign store_port.read_index = byte_index;

  // Page select register
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      page_number <= `PAGE_RESET;
    end else if (WRITE_STROBE && ADDRESS == `ADDR_PAGE_SELECT) begin
      page_number <= WRITE_DATA[2:0];
    end
  end

  // Initialisation mode request bit; starts in init so filters can be set up
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      init_mode <= `INIT_CONTROL_RESET;
    end else if (WRITE_STROBE && ADDRESS == `ADDR_INIT_CONTROL) begin
      init_mode <= WRITE_DATA[0];
    end
  end

  // Mode registers, changed only by software writes on page 6
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      filter_mode_low_group <= `MODE_RESET;
      filter_mode_high_group <= `MODE_RESET;
    end else if (WRITE_STROBE && page_number == `PAGE_CONFIG) begin
      if (ADDRESS == `ADDR_MODE_LOW_GROUP) begin
        filter_mode_low_group <= WRITE_DATA;
      end
      if (ADDRESS == `ADDR_MODE_HIGH_GROUP) begin
        filter_mode_high_group <= WRITE_DATA & `MODE_HIGH_GROUP_MASK;
      end
    end
  end

  // Pair configuration registers
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      filter_config_pair_01 <= `CONFIG_RESET;
      filter_config_pair_23 <= `CONFIG_RESET;
      filter_config_pair_45 <= `CONFIG_RESET;
    end else if (WRITE_STROBE && page_number == `PAGE_CONFIG) begin
      if (ADDRESS == `ADDR_CONFIG_PAIR_01) begin
        filter_config_pair_01 <= merge_config(filter_config_pair_01, WRITE_DATA, init_mode);
      end
      if (ADDRESS == `ADDR_CONFIG_PAIR_23) begin
        filter_config_pair_23 <= merge_config(filter_config_pair_23, WRITE_DATA, init_mode);
      end
      if (ADDRESS == `ADDR_CONFIG_PAIR_45) begin
        filter_config_pair_45 <= merge_config(filter_config_pair_45, WRITE_DATA, init_mode);
      end
    end
  end

  // Read mux for the registered registers; unmapped and reserved read zero
  always_comb begin
    direct_read = 8'h00;
    if (ADDRESS == `ADDR_PAGE_SELECT) begin
      direct_read = {5'b0_0000, page_number};
    end else if (ADDRESS == `ADDR_INIT_CONTROL) begin
      direct_read = {7'b000_0000, init_mode};
    end else if (page_number == `PAGE_CONFIG) begin
      case (ADDRESS)
        `ADDR_MODE_LOW_GROUP: direct_read = filter_mode_low_group;
        `ADDR_MODE_HIGH_GROUP: direct_read = filter_mode_high_group;
        `ADDR_CONFIG_PAIR_01: direct_read = filter_config_pair_01;
        `ADDR_CONFIG_PAIR_23: direct_read = filter_config_pair_23;
        `ADDR_CONFIG_PAIR_45: direct_read = filter_config_pair_45;
        default: direct_read = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_read_data = 8'h00;
    if (READ_STROBE) begin
      next_read_data = (window_hit && byte_page) ? store_port.read_data : direct_read;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      READ_DATA <= 8'h00;
    end else begin
      READ_DATA <= next_read_data;
    end
  end

  // Configuration outputs toward the matcher, registered
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      FILTER_ACTIVE <= 6'h00;
      FILTER_SCALE <= 12'h000;
      HIGH_HALF_LIST_MODE <= 6'h00;
      LOW_HALF_LIST_MODE <= 6'h00;
      FILTER_FIFO_ASSIGN <= 6'h00;
    end else begin
      FILTER_ACTIVE <= active_all;
      FILTER_SCALE <= {filter_config_pair_45[6:5], filter_config_pair_45[2:1],
                       filter_config_pair_23[6:5], filter_config_pair_23[2:1],
                       filter_config_pair_01[6:5], filter_config_pair_01[2:1]};
      HIGH_HALF_LIST_MODE <= {filter_mode_high_group[3], filter_mode_high_group[1],
                              filter_mode_low_group[7], filter_mode_low_group[5],
                              filter_mode_low_group[3], filter_mode_low_group[1]};
      LOW_HALF_LIST_MODE <= {filter_mode_high_group[2], filter_mode_high_group[0],
                             filter_mode_low_group[6], filter_mode_low_group[4],
                             filter_mode_low_group[2], filter_mode_low_group[0]};
      FILTER_FIFO_ASSIGN <= 6'h00; // FIFO assign bits forced zero in this layout
    end
  end
endmodule

// >>> test/can_filter_checker.sv
`timescale 1ns/1ps
`include "can_filter_defs.svh"
// Watches the register port and the decoded configuration outputs
module can_filter_checker (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [7:0] ADDRESS,
  input wire can_filter_pkg::byte_type WRITE_DATA,
  input wire logic WRITE_STROBE,
  input wire logic READ_STROBE,
  input wire can_filter_pkg::byte_type READ_DATA,
  input wire logic [5:0] FILTER_ACTIVE,
  input wire logic [11:0] FILTER_SCALE,
  input wire logic [5:0] HIGH_HALF_LIST_MODE,
  input wire logic [5:0] LOW_HALF_LIST_MODE,
  input wire logic [5:0] FILTER_FIFO_ASSIGN
);
  import can_filter_pkg::*;
  logic [2:0] page;
  wire logic [5:0] h = HIGH_HALF_LIST_MODE;
  wire logic [5:0] l = LOW_HALF_LIST_MODE;
  wire logic [5:0] f = FILTER_ACTIVE;
  wire logic [11:0] s = FILTER_SCALE;
  // Shadow page number, so reads in the window can be decoded here
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      page <= `PAGE_RESET;
    end else if (WRITE_STROBE && ADDRESS == `ADDR_PAGE_SELECT) begin
      page <= WRITE_DATA[2:0];
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence s_rd(p, a);
    READ_STROBE && page == p && ADDRESS == a;
  endsequence
  property p_mode_low; s_rd(3'h6, 8'h78) |=> READ_DATA == {h[3], l[3], h[2], l[2], h[1], l[1], h[0], l[0]}; endproperty
  a_mode_low: assert property (p_mode_low) else $error("low mode group readback wrong");
  property p_mode_high; s_rd(3'h6, 8'h79) |=> READ_DATA == {4'h0, h[5], l[5], h[4], l[4]}; endproperty
  a_mode_high: assert property (p_mode_high) else $error("high mode group readback wrong");
  property p_cfg23; s_rd(3'h6, 8'h7B) |=> READ_DATA == {1'b0, s[7:6], f[3], 1'b0, s[5:4], f[2]}; endproperty
  a_cfg23: assert property (p_cfg23) else $error("pair 23 readback wrong");
  property p_cfg45; s_rd(3'h6, 8'h7C) |=> READ_DATA == {1'b0, s[11:10], f[5], 1'b0, s[9:8], f[4]}; endproperty
  a_cfg45: assert property (p_cfg45) else $error("pair 45 readback wrong");
  property p_cfg_rsv; READ_STROBE && page == 3'h6 && ADDRESS[7:3] == 5'h0F && ADDRESS[2:0] > 3'h4 |=> READ_DATA == 8'h00;
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("reserved config place not zero");
  property p_page5; READ_STROBE && page == 3'h5 && ADDRESS[7:4] == 4'h7 |=> READ_DATA == 8'h00; endproperty
  a_page5: assert property (p_page5) else $error("unused page not zero");
  property p_fifo; FILTER_FIFO_ASSIGN == 6'h00; endproperty
  a_fifo: assert property (p_fifo) else $error("reserved fifo bits set");
  property p_hold; !WRITE_STROBE [*3] |-> $stable(f) && $stable(s) && $stable(h) && $stable(l); endproperty
  a_hold: assert property (p_hold) else $error("config changed without a write");
  property p_idle; !READ_STROBE |=> READ_DATA == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read cycle");
endmodule
bind can_acceptance_filter_config can_filter_checker chk_u (.CLOCK(CLOCK), .RESETN(RESETN), .ADDRESS(ADDRESS),
  .WRITE_DATA(WRITE_DATA), .WRITE_STROBE(WRITE_STROBE), .READ_STROBE(READ_STROBE), .READ_DATA(READ_DATA),
  .FILTER_ACTIVE(FILTER_ACTIVE), .FILTER_SCALE(FILTER_SCALE), .HIGH_HALF_LIST_MODE(HIGH_HALF_LIST_MODE),
  .LOW_HALF_LIST_MODE(LOW_HALF_LIST_MODE), .FILTER_FIFO_ASSIGN(FILTER_FIFO_ASSIGN));

// >>> test/tb.sv
`timescale 1ns/1ps
`include "can_filter_defs.svh"
module tb;
  import can_filter_pkg::*;
  logic CLOCK = 0;
  logic RESETN = 0;
  logic WRITE_STROBE = 0;
  logic READ_STROBE = 0;
  logic [7:0] ADDRESS = 8'h00;
  byte_type WRITE_DATA = 8'h00;
  byte_type READ_DATA;
  byte_type v;
  byte_type fb [48];
  logic [5:0] FILTER_ACTIVE, HIGH_HALF_LIST_MODE, LOW_HALF_LIST_MODE;
  logic [11:0] FILTER_SCALE;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  always #2.5 CLOCK = ~CLOCK;
  can_acceptance_filter_config dut_u (.CLOCK(CLOCK), .RESETN(RESETN), .ADDRESS(ADDRESS), .WRITE_DATA(WRITE_DATA),
    .WRITE_STROBE(WRITE_STROBE), .READ_STROBE(READ_STROBE), .READ_DATA(READ_DATA), .FILTER_ACTIVE(FILTER_ACTIVE),
    .FILTER_SCALE(FILTER_SCALE), .HIGH_HALF_LIST_MODE(HIGH_HALF_LIST_MODE), .LOW_HALF_LIST_MODE(LOW_HALF_LIST_MODE),
    .FILTER_FIFO_ASSIGN());
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input byte_type g, input byte_type e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input byte_type d);
    @(posedge CLOCK);
    ADDRESS <= a;
    WRITE_DATA <= d;
    WRITE_STROBE <= 1'b1;
    @(posedge CLOCK);
    WRITE_STROBE <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, input byte_type e);
    @(posedge CLOCK);
    ADDRESS <= a;
    READ_STROBE <= 1'b1;
    @(posedge CLOCK);
    READ_STROBE <= 1'b0;
    #1 chk(READ_DATA, e);
  endtask
  // Outside init mode only the activate bits take the new value
  function automatic byte_type exp_cfg(input byte_type old, input byte_type d, input logic init);
    return init ? (d & 8'h77) : ((d & 8'h11) | (old & 8'h66));
  endfunction
  // Cycle ceiling well above the roughly 400 cycles the tests need
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    v = $urandom(73250);
    repeat (20) @(posedge CLOCK);
    RESETN <= 1'b1;
    wr(`ADDR_PAGE_SELECT, 8'h06);
    rd(`ADDR_PAGE_SELECT, 8'h06);
    rd(`ADDR_INIT_CONTROL, 8'h01);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h00);
    rd(8'h7B, 8'h00);
    rd(8'h7C, 8'h00);
    $display("reset values done");
    // All-ones first, as it exposes every reserved bit
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      wr(8'h78, v);
      rd(8'h78, v);
      wr(8'h79, v);
      rd(8'h79, v & 8'h0F);
      wr(8'h7B, v);
      rd(8'h7B, exp_cfg(8'h00, v, 1'b1));
      wr(8'h7C, v);
      rd(8'h7C, exp_cfg(8'h00, v, 1'b1));
      wr(8'h7A, v);
      rd(8'h7A, exp_cfg(8'h00, v, 1'b1));
    end
    rd(8'h7D, 8'h00);
    $display("mode and config done");
    // Filters go inactive before their bytes are edited
    wr(8'h7A, 8'h00);
    wr(8'h7B, 8'h00);
    wr(8'h7C, 8'h00);
    for (int p = 2; p < 5; p++) begin
      wr(`ADDR_PAGE_SELECT, 8'(p));
      for (int k = 0; k < 16; k++) begin
        fb[(p - 2) * 16 + k] = 8'($urandom);
        wr(8'h70 + 8'(k), fb[(p - 2) * 16 + k]);
      end
      for (int k = 0; k < 16; k++) begin
        rd(8'h70 + 8'(k), fb[(p - 2) * 16 + k]);
      end
    end
    $display("filter bytes done");
    // Active filter 3 must keep its bytes; filter 2 stays editable
    wr(`ADDR_PAGE_SELECT, 8'h06);
    wr(8'h7B, 8'h10);
    wr(`ADDR_PAGE_SELECT, 8'h03);
    chk({2'b00, FILTER_ACTIVE}, 8'h08);
    wr(8'h78, ~fb[24]);
    rd(8'h78, fb[24]);
    wr(8'h70, ~fb[16]);
    rd(8'h70, ~fb[16]);
    wr(`ADDR_PAGE_SELECT, 8'h05);
    rd(8'h70, 8'h00);
    $display("write protection done");
    // Leaving init mode freezes the scale fields
    wr(`ADDR_PAGE_SELECT, 8'h06);
    wr(`ADDR_INIT_CONTROL, 8'h00);
    rd(`ADDR_INIT_CONTROL, 8'h00);
    wr(8'h7B, 8'h67);
    rd(8'h7B, exp_cfg(8'h10, 8'h67, 1'b0));
    wr(`ADDR_INIT_CONTROL, 8'h01);
    wr(8'h7B, 8'h66);
    rd(8'h7B, exp_cfg(8'h11, 8'h66, 1'b1));
    chk(FILTER_SCALE[7:0], 8'hF0);
    $display("init mode done");
    end_sim();
  end
endmodule
